// file: pm_power_down.sv
`timescale 1ns/1ps
`include "pm_map.svh"
module pm_power_down #(
    parameter int SEC_CYCLES = `SECOND_NS / `CLK_NS,
    parameter int MIN_SECS   = `MINUTE_SEC
) (
    input  wire logic             clk,
    input  wire logic             rst_n,
    input  wire logic             ext_mode,
    input  wire pm_pkg::cfg_req_t cfg,
    output logic [7:0]            cfg_rdata,
    input  wire logic [3:0]       unit_activity,
    input  wire logic [3:0]       unit_irq,
    input  wire logic [9:0]       io_addr,
    output pm_pkg::io_hit_t       io_hit,
    output logic [3:0]            unit_sleep,
    output logic                  chip_sleep,
    output logic                  pm_enable,
    output logic                  serial_irq_mode,
    output logic [7:0]            irq_pin_out,
    output logic [7:0]            irq_pin_oe_n,
    output logic [3:0]            serirq_req
);

    localparam int SW = $clog2(SEC_CYCLES);
    localparam int MW = $clog2(MIN_SECS);

    // Refuse prescaler values the counters cannot serve
    if (SEC_CYCLES < 2 || MIN_SECS < 2) begin : g_chk
        $error("prescaler parameters too small");
    end

    // Nibble value k+1 of a unit hits pin k, only when 1..8
    function automatic logic [7:0] pin_sel(input logic [3:0] s);
        logic [7:0] v;
        v = 8'h00;
        if (s >= 4'h1 && s <= 4'h8) begin
            v = 8'h01 << (s - 4'h1);
        end
        return v;
    endfunction

    // Address inside a four-byte block starting at b
    function automatic logic in_blk(input logic [9:0] a,
                                    input logic [9:0] b);
        logic [10:0] d;
        d = {1'b0, a} - {1'b0, b};
        return d < `BLK_LEN;
    endfunction

    logic [7:0] index_reg;
    logic [7:0] share_reg;
    logic [7:0] rt_prt_reg;
    logic [7:0] rt_ser_reg;
    logic [7:0] rt_fdc_reg;
    logic [7:0] mode_reg;
    logic [7:0] en_reg;
    logic [7:0] pm1_reg;
    logic [7:0] gpe_reg;
    logic [7:0] gsb_reg;
    logic [7:0] misc_reg;
    logic [7:0] cnt_reg [4];
    logic [7:0] tmr_reg [4];
    logic [7:0] tmr_next [4];
    pm_pkg::pd_state_t st_reg [4];
    pm_pkg::pd_state_t st_next [4];
    pm_pkg::pd_state_t gs_reg;
    pm_pkg::pd_state_t gs_next;
    logic [7:0] gtmr_reg;
    logic [7:0] gtmr_next;
    logic [3:0] idle_reg;
    logic [3:0] idle_next;
    logic [3:0] wake_reg;
    logic [3:0] wake_next;
    logic [3:0] idle_set;
    logic [3:0] wake_set;
    logic [3:0] active;
    logic [SW-1:0] sec_cnt;
    logic [MW-1:0] min_cnt;
    logic       sec_tick;
    logic       min_tick;
    logic [7:0] rd_mux;
    logic [7:0] lvl;
    logic [7:0] sel;

    // Port strobes; only honoured in extended function mode
    wire wr_idx  = ext_mode & cfg.wr & ~cfg.data_sel;
    wire wr_dat  = ext_mode & cfg.wr & cfg.data_sel;
    wire rd_any  = ext_mode & cfg.rd;
    wire chip_en = en_reg[`BIT_CHIP_EN];
    wire serial  = mode_reg[`BIT_IRQMODE];
    wire tick    = misc_reg[`BIT_TICK_SEL] ? min_tick
                                           : sec_tick;
    wire all_sl  = &unit_sleep;
    wire w1c_idl = wr_dat && index_reg == `IDX_IDLE;
    wire w1c_wak = wr_dat && index_reg == `IDX_WAKE;

    // Base addresses: register bits sit above the alignment
    wire [9:0] pm1_base = {pm1_reg[7:2], 4'h0};
    wire [9:0] gpe_base = {gpe_reg[7:1], 3'h0};
    wire pm1_ok = chip_en && pm1_base >= `BASE_MIN
                  && pm1_base <= `PM1_MAX;
    wire gpe_ok = chip_en && gpe_base >= `BASE_MIN
                  && gpe_base <= `GPE_MAX;

    // Second and minute enables from the main clock
    assign sec_tick = sec_cnt == SW'(SEC_CYCLES - 1);
    assign min_tick = sec_tick
                      && min_cnt == MW'(MIN_SECS - 1);

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            sec_cnt <= '0;
            min_cnt <= '0;
        end else begin
            sec_cnt <= sec_tick ? '0 : sec_cnt + 1'b1;
            if (sec_tick) begin
                min_cnt <= min_tick ? '0 : min_cnt + 1'b1;
            end
        end
    end

    // Configuration register writes, reserved bits masked
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            index_reg  <= `RST_BYTE;
            share_reg  <= `RST_BYTE;
            rt_prt_reg <= `RST_BYTE;
            rt_ser_reg <= `RST_BYTE;
            rt_fdc_reg <= `RST_BYTE;
            mode_reg   <= `RST_BYTE;
            en_reg     <= `RST_BYTE;
            pm1_reg    <= `RST_BYTE;
            gpe_reg    <= `RST_BYTE;
            gsb_reg    <= `RST_BYTE;
            misc_reg   <= `RST_BYTE;
            for (int i = 0; i < 4; i++) begin
                cnt_reg[i] <= `RST_BYTE;
            end
        end else if (wr_idx) begin
            index_reg <= cfg.wdata;
        end else if (wr_dat) begin
            case (index_reg)
                `IDX_SHARE:   share_reg  <= cfg.wdata;
                `IDX_RT_PRT:  rt_prt_reg <= cfg.wdata;
                `IDX_RT_SER:  rt_ser_reg <= cfg.wdata;
                `IDX_RT_FDC:  rt_fdc_reg <= cfg.wdata;
                `IDX_IRQMODE: mode_reg <= cfg.wdata & `MASK_MODE;
                `IDX_PM_EN:   en_reg   <= cfg.wdata & `MASK_PM_EN;
                `IDX_PM1:     pm1_reg  <= cfg.wdata & `MASK_PM1;
                `IDX_GPE:     gpe_reg  <= cfg.wdata & `MASK_GPE;
                `IDX_CNT_UA:  cnt_reg[1] <= cfg.wdata;
                `IDX_CNT_UB:  cnt_reg[0] <= cfg.wdata;
                `IDX_CNT_FDC: cnt_reg[2] <= cfg.wdata;
                `IDX_CNT_PRT: cnt_reg[3] <= cfg.wdata;
                `IDX_GSB:     gsb_reg  <= cfg.wdata;
                `IDX_MISC:    misc_reg <= cfg.wdata & `MASK_MISC;
                default:      index_reg <= index_reg;
            endcase
        end
    end

    // Read-back mux; unknown indexes read zero
    always_comb begin
        case (index_reg)
            `IDX_SHARE:   rd_mux = share_reg;
            `IDX_RT_PRT:  rd_mux = rt_prt_reg;
            `IDX_RT_SER:  rd_mux = rt_ser_reg;
            `IDX_RT_FDC:  rd_mux = rt_fdc_reg;
            `IDX_IRQMODE: rd_mux = mode_reg;
            `IDX_PM_EN:   rd_mux = en_reg;
            `IDX_PM1:     rd_mux = pm1_reg;
            `IDX_GPE:     rd_mux = gpe_reg;
            `IDX_CNT_UA:  rd_mux = cnt_reg[1];
            `IDX_CNT_UB:  rd_mux = cnt_reg[0];
            `IDX_CNT_FDC: rd_mux = cnt_reg[2];
            `IDX_CNT_PRT: rd_mux = cnt_reg[3];
            `IDX_GSB:     rd_mux = gsb_reg;
            `IDX_MISC:    rd_mux = misc_reg;
            `IDX_IDLE:    rd_mux = {4'h0, idle_reg};
            `IDX_WAKE:    rd_mux = {4'h0, wake_reg};
            default:      rd_mux = 8'h00;
        endcase
    end

    // Per-unit power-down machines
    always_comb begin
        for (int i = 0; i < 4; i++) begin
            active[i]   = chip_en & en_reg[i];
            st_next[i]  = st_reg[i];
            tmr_next[i] = tmr_reg[i];
            idle_set[i] = 1'b0;
            wake_set[i] = 1'b0;
            if (!active[i]) begin
                st_next[i]  = pm_pkg::WORKING;
                tmr_next[i] = cnt_reg[i];
            end else if (cnt_reg[i] == 8'h00) begin
                st_next[i] = st_reg[i];
            end else if (unit_activity[i]) begin
                st_next[i]  = pm_pkg::WORKING;
                tmr_next[i] = cnt_reg[i];
                wake_set[i] = st_reg[i] == pm_pkg::SLEEPING;
            end else if (tick && st_reg[i] == pm_pkg::WORKING) begin
                if (tmr_reg[i] <= 8'h01) begin
                    tmr_next[i] = 8'h00;
                    st_next[i]  = pm_pkg::SLEEPING;
                    idle_set[i] = 1'b1;
                end else begin
                    tmr_next[i] = tmr_reg[i] - 8'h01;
                end
            end
        end
    end

    // Status bits: hardware set wins over the write-one clear
    assign idle_next = (idle_reg & ~(w1c_idl ? cfg.wdata[3:0]
                        : 4'h0) & ~wake_set) | idle_set;
    assign wake_next = (wake_reg & ~(w1c_wak ? cfg.wdata[3:0]
                        : 4'h0) & ~idle_set) | wake_set;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            idle_reg <= 4'h0;
            wake_reg <= 4'h0;
            for (int i = 0; i < 4; i++) begin
                st_reg[i]  <= pm_pkg::WORKING;
                tmr_reg[i] <= 8'h00;
            end
        end else begin
            idle_reg <= idle_next;
            wake_reg <= wake_next;
            st_reg   <= st_next;
            tmr_reg  <= tmr_next;
        end
    end

    // Chip power-down machine, armed once every unit sleeps
    always_comb begin
        gs_next   = gs_reg;
        gtmr_next = gtmr_reg;
        if (!chip_en) begin
            gs_next   = pm_pkg::WORKING;
            gtmr_next = gsb_reg;
        end else if (gsb_reg == 8'h00) begin
            gs_next = gs_reg;
        end else if (!all_sl) begin
            gs_next   = pm_pkg::WORKING;
            gtmr_next = gsb_reg;
        end else if (tick && gs_reg == pm_pkg::WORKING) begin
            if (gtmr_reg <= 8'h01) begin
                gtmr_next = 8'h00;
                gs_next   = pm_pkg::SLEEPING;
            end else begin
                gtmr_next = gtmr_reg - 8'h01;
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            gs_reg   <= pm_pkg::WORKING;
            gtmr_reg <= 8'h00;
        end else begin
            gs_reg   <= gs_next;
            gtmr_reg <= gtmr_next;
        end
    end

    // Interrupt routing: selected pins and their levels
    always_comb begin
        sel = pin_sel(rt_ser_reg[3:0]) | pin_sel(rt_ser_reg[7:4])
            | pin_sel(rt_fdc_reg[7:4]) | pin_sel(rt_prt_reg[3:0]);
        lvl = (pin_sel(rt_ser_reg[3:0]) & {8{unit_irq[0]}})
            | (pin_sel(rt_ser_reg[7:4]) & {8{unit_irq[1]}})
            | (pin_sel(rt_fdc_reg[7:4]) & {8{unit_irq[2]}})
            | (pin_sel(rt_prt_reg[3:0]) & {8{unit_irq[3]}});
    end

    // Shared pins drive only while asserted; serial mode frees all
    wire [7:0] drive = serial ? 8'h00
                     : (sel & ~share_reg) | (sel & share_reg & lvl);

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            irq_pin_out  <= 8'h00;
            irq_pin_oe_n <= 8'hff;
            serirq_req   <= 4'h0;
        end else begin
            irq_pin_out  <= lvl;
            irq_pin_oe_n <= ~drive;
            serirq_req   <= serial ? unit_irq : 4'h0;
        end
    end

    // ACPI block decode and read data, registered
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            io_hit    <= '0;
            cfg_rdata <= 8'h00;
        end else begin
            io_hit.pm1_evt <= pm1_ok && in_blk(io_addr, pm1_base);
            io_hit.pm1_cnt <= pm1_ok && in_blk(io_addr,
                              pm1_base + `PM1_CNT_OFS);
            io_hit.pm_tmr  <= pm1_ok && in_blk(io_addr,
                              pm1_base + `PM_TMR_OFS);
            io_hit.gpe0    <= gpe_ok && in_blk(io_addr, gpe_base);
            io_hit.gpe1    <= gpe_ok && in_blk(io_addr,
                              gpe_base + `GPE1_OFS);
            if (rd_any) begin
                cfg_rdata <= cfg.data_sel ? rd_mux : index_reg;
            end
        end
    end

    // State outputs
    always_comb begin
        for (int i = 0; i < 4; i++) begin
            unit_sleep[i] = st_reg[i] == pm_pkg::SLEEPING;
        end
    end
    assign chip_sleep      = gs_reg == pm_pkg::SLEEPING;
    assign pm_enable       = chip_en;
    assign serial_irq_mode = serial;

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    chip_off_a: assert property (
        !chip_en |=> !chip_sleep && unit_sleep == 4'h0)
        else $error("sleep while chip disabled");
    unit_gate_a: assert property (
        !active[0] |=> !unit_sleep[0] && !$rose(idle_reg[0]))
        else $error("disabled unit asleep");
    wake_load_a: assert property (
        active[0] && cnt_reg[0] != 8'h00 && unit_activity[0]
        |=> tmr_reg[0] == $past(cnt_reg[0]) && !unit_sleep[0])
        else $error("wake did not reload");
    expire_a: assert property (
        active[0] && cnt_reg[0] != 8'h00 && !unit_activity[0]
        && tick && !unit_sleep[0] && tmr_reg[0] == 8'h01
        |=> unit_sleep[0] && idle_reg[0])
        else $error("expiry missed");
    zero_hold_a: assert property (
        active[1] && cnt_reg[1] == 8'h00
        |=> unit_sleep[1] == $past(unit_sleep[1]))
        else $error("zero count changed state");
    tick_only_a: assert property (
        active[2] && !tick && !unit_activity[2] && !wr_dat
        |=> tmr_reg[2] == $past(tmr_reg[2]))
        else $error("timer moved without tick");
    glob_entry_a: assert property (
        $rose(chip_sleep) |-> $past(all_sl) && $past(tick))
        else $error("chip slept early");
    glob_zero_a: assert property (
        chip_en && gsb_reg == 8'h00 && !wr_dat
        |=> chip_sleep == $past(chip_sleep))
        else $error("zero standby changed state");
    serial_a: assert property (
        serial |=> irq_pin_oe_n == 8'hff)
        else $error("pin driven in serial mode");
    base_lsb_a: assert property (
        rd_any && cfg.data_sel && index_reg == `IDX_PM1
        |=> cfg_rdata[1:0] == 2'b00)
        else $error("reserved base bits set");
    set_wins_a: assert property (
        idle_set[3] |=> idle_reg[3])
        else $error("idle set lost");

endmodule

// file: pm_map.svh
`ifndef PM_MAP_SVH
`define PM_MAP_SVH
// Operation
// - Mode bit picks ISA pins or serial IRQ.
// - Pin mode routes unit IRQs, shared pins marked.
// - Chip enable clear disables all power management.
// - Unit power management needs unit and chip enable.
// - PM1 base bits 7..2, aligned, 100H to 3F0H.
// - PM1 control at base+4, timer at base+8.
// - GPE0 base bits 7..1, 100H-3F8H, GPE1 +4.
// - Waking unit reloads its idle count.
// - Idle timer reaching zero puts unit asleep.
// - Idle count zero freezes unit state.
// - All counts tick in seconds or minutes.
// - Idle count acts only when both enabled.
// - All units asleep starts global standby countdown.
// - Global count needs chip enable; zero freezes.
// - Reserved low base bits read zero.
// - Resolution bit zero seconds, one minutes.
// - Idle status set on expiry, write-one clears.
// - Wake status set on wake, timer reloads.
`define IDX_SHARE    8'h18
`define IDX_RT_PRT   8'h27
`define IDX_RT_SER   8'h28
`define IDX_RT_FDC   8'h29
`define IDX_IRQMODE  8'h31
`define IDX_PM_EN    8'h32
`define IDX_PM1      8'h33
`define IDX_GPE      8'h34
`define IDX_CNT_UA   8'h35
`define IDX_CNT_UB   8'h36
`define IDX_CNT_FDC  8'h37
`define IDX_CNT_PRT  8'h38
`define IDX_GSB      8'h39
`define IDX_MISC     8'h3a
`define IDX_IDLE     8'h40
`define IDX_WAKE     8'h41
`define BIT_IRQMODE  2
`define BIT_CHIP_EN  7
`define BIT_TICK_SEL 5
`define MASK_PM_EN   8'h8f
`define MASK_MODE    8'h04
`define MASK_PM1     8'hfc
`define MASK_GPE     8'hfe
`define MASK_MISC    8'h23
`define RST_BYTE     8'h00
`define BASE_MIN     10'h100
`define PM1_MAX      10'h3f0
`define GPE_MAX      10'h3f8
`define PM1_CNT_OFS  10'h004
`define PM_TMR_OFS   10'h008
`define GPE1_OFS     10'h004
`define BLK_LEN      11'h004
`define SECOND_NS    1000000000
`define CLK_NS       8
`define MINUTE_SEC   60
`endif

// file: pm_pkg.sv
package pm_pkg;
    // Power-down machine states
    typedef enum logic {
        WORKING  = 1'b0,
        SLEEPING = 1'b1
    } pd_state_t;
    // One access on the index/data port pair
    typedef struct packed {
        logic       data_sel;
        logic       wr;
        logic       rd;
        logic [7:0] wdata;
    } cfg_req_t;
    // Decode hits of the ACPI register blocks
    typedef struct packed {
        logic pm1_evt;
        logic pm1_cnt;
        logic pm_tmr;
        logic gpe0;
        logic gpe1;
    } io_hit_t;
endpackage

// file: host_port.sv
`timescale 1ns/1ps
// Host software model on the index/data port pair
module host_port (
    input  wire logic        clk,
    output logic             ext_mode,
    output pm_pkg::cfg_req_t cfg,
    input  wire logic [7:0]  cfg_rdata
);
    // Extended mode entered, strobes idle from time zero
    initial begin
        ext_mode = 1'b1;
        cfg = '0;
    end
    // One strobe held over one rising edge, then released with data scrambled
    task automatic access(input logic sel, input logic wr,
                          input logic [7:0] d);
        @(negedge clk);
        cfg = '{data_sel: sel, wr: wr, rd: !wr, wdata: d};
        @(negedge clk);
        cfg = '{data_sel: !sel, wr: 1'b0, rd: 1'b0, wdata: ~d};
    endtask
    // Enter or leave extended function mode between accesses
    task automatic set_mode(input logic m);
        ext_mode = m;
    endtask
    // Index port first, then data port
    task automatic wr_reg(input logic [7:0] idx, input logic [7:0] d);
        access(1'b0, 1'b1, idx);
        access(1'b1, 1'b1, d);
    endtask
    // Read data is registered on the read edge
    task automatic rd_reg(input logic [7:0] idx, output logic [7:0] d);
        access(1'b0, 1'b1, idx);
        access(1'b1, 1'b0, 8'h00);
        d = cfg_rdata;
    endtask
endmodule

// file: auto_power_down_timers_tb.sv
`timescale 1ns/1ps
module auto_power_down_timers_tb;
    localparam int SEC = 4;
    localparam int MIN = 3;
    localparam logic [7:0] CIDX [4] = '{8'h36, 8'h35, 8'h37, 8'h38};
    logic             clk;
    logic             rst_n;
    logic             ext_mode;
    pm_pkg::cfg_req_t cfg;
    logic [7:0]       cfg_rdata;
    logic [7:0]       rd;
    logic [7:0]       v;
    logic [7:0]       pin_out;
    logic [7:0]       pin_oe_n;
    logic [3:0]       act;
    logic [3:0]       irq;
    logic [3:0]       unit_sleep;
    logic [3:0]       serirq;
    logic [9:0]       io_addr;
    logic [9:0]       pb;
    logic [9:0]       gb;
    pm_pkg::io_hit_t  io_hit;
    logic             chip_sleep;
    logic             pm_enable;
    logic             ser_mode;
    int               n_fail;
    int               n_compared;
    int               cyc;
    int               k;
    int               u;
    int               cnt [4];

    pm_power_down #(.SEC_CYCLES(SEC), .MIN_SECS(MIN)) dut (
        .clk(clk), .rst_n(rst_n), .ext_mode(ext_mode), .cfg(cfg),
        .cfg_rdata(cfg_rdata), .unit_activity(act), .unit_irq(irq),
        .io_addr(io_addr), .io_hit(io_hit), .unit_sleep(unit_sleep),
        .chip_sleep(chip_sleep), .pm_enable(pm_enable),
        .serial_irq_mode(ser_mode), .irq_pin_out(pin_out),
        .irq_pin_oe_n(pin_oe_n), .serirq_req(serirq));
    host_port host (.clk(clk), .ext_mode(ext_mode), .cfg(cfg),
        .cfg_rdata(cfg_rdata));

    // Expected decode hits from the programmed bases
    function automatic logic [4:0] hits(input logic [9:0] a,
                                        input logic en);
        logic pv;
        logic gv;
        pv = en && pb >= 10'h100 && pb <= 10'h3f0;
        gv = en && gb >= 10'h100 && gb <= 10'h3f8;
        hits = {pv && a >= pb && a < pb + 4, pv && a >= pb + 4 && a < pb + 8,
                pv && a >= pb + 8 && a < pb + 12, gv && a >= gb && a < gb + 4,
                gv && a >= gb + 4 && a < gb + 8};
    endfunction
    task automatic chk(input string what, input logic [7:0] exp,
                       input logic [7:0] got);
        n_compared++;
        if (got !== exp) begin
            n_fail++;
            $display("unexpected %s: expected %h, seen %h", what, exp, got);
        end
    endtask
    task automatic rchk(input logic [7:0] idx, input logic [7:0] exp);
        host.rd_reg(idx, rd);
        chk($sformatf("register %h", idx), exp, rd);
    endtask
    task automatic waitn(input int m);
        repeat (m) @(negedge clk);
    endtask
    // One-cycle activity pulse; its sampling edge has passed on return
    task automatic wake(input logic [3:0] u);
        @(negedge clk);
        act = u;
        @(negedge clk);
        act = 4'h0;
    endtask
    // Awake after p*(n-1) cycles, asleep by p*n+2, for tick period p
    task automatic expect_sleep(input int u, input int n, input int p);
        wake(4'h1 << u);
        waitn(p * (n - 1));
        chk("unit_sleep early", 8'h00, {7'h0, unit_sleep[u]});
        waitn(p + 2);
        chk("unit_sleep late", 8'h01, {7'h0, unit_sleep[u]});
    endtask
    task automatic probe(input logic [9:0] a, input logic en);
        @(negedge clk);
        io_addr = a;
        @(negedge clk);
        chk("io_hit", {3'h0, hits(a, en)}, {3'h0, io_hit});
    endtask
    task automatic tally_and_finish();
        $display("compared %0d, mismatches %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    // Cycle ceiling cuts a hang short
    always @(posedge clk) begin
        cyc++;
        if (cyc == 20000) begin
            n_fail++;
            tally_and_finish();
        end
    end

    initial begin
        rst_n = 1'b0;
        act = 4'h0;
        irq = 4'h0;
        io_addr = 10'h000;
        v = 8'($urandom(18));
        repeat (20) @(negedge clk);
        rst_n = 1'b1;
        for (k = 8'h32; k <= 8'h39; k++)
            rchk(k[7:0], 8'h00);
        chk("oe_n reset", 8'hff, pin_oe_n);
        $display("reset test done");
        // Counts round trip, then parked at zero
        for (k = 0; k < 5; k++) begin
            v = 8'($urandom);
            host.wr_reg(8'h35 + k[7:0], v);
            rchk(8'h35 + k[7:0], v);
            host.wr_reg(8'h35 + k[7:0], 8'h00);
        end
        host.wr_reg(8'h32, 8'hff);
        rchk(8'h32, 8'h8f);
        chk("pm_enable", 8'h01, {7'h0, pm_enable});
        host.wr_reg(8'h33, 8'hff);
        rchk(8'h33, 8'hfc);
        host.wr_reg(8'h34, 8'hff);
        rchk(8'h34, 8'hfe);
        host.wr_reg(8'h31, 8'hff);
        rchk(8'h31, 8'h04);
        chk("serial mode", 8'h01, {7'h0, ser_mode});
        host.wr_reg(8'h31, 8'h00);
        host.wr_reg(8'h3b, 8'hff);
        rchk(8'h3b, 8'h00);
        // Index port reads back the index; strobes need extended mode
        host.access(1'b0, 1'b0, 8'h00);
        chk("index read", 8'h3b, cfg_rdata);
        host.set_mode(1'b0);
        host.wr_reg(8'h39, 8'h5a);
        host.set_mode(1'b1);
        rchk(8'h39, 8'h00);
        $display("register test done");
        // Each unit: sleep after its count, wake on activity
        for (k = 0; k < 4; k++) begin
            cnt[k] = $urandom_range(4, 3);
            host.wr_reg(CIDX[k], 8'(cnt[k]));
            expect_sleep(k, cnt[k], SEC);
            host.rd_reg(8'h40, rd);
            chk("idle bit", 8'h01, {7'h0, rd[k]});
            wake(4'h1 << k);
            chk("woken", 8'h00, {7'h0, unit_sleep[k]});
            host.rd_reg(8'h41, rd);
            chk("wake bit", 8'h01, {7'h0, rd[k]});
            host.rd_reg(8'h40, rd);
            chk("idle cleared", 8'h00, {7'h0, rd[k]});
        end
        waitn(24);
        chk("all asleep", 8'h0f, {4'h0, unit_sleep});
        chk("chip frozen", 8'h00, {7'h0, chip_sleep});
        rchk(8'h40, 8'h0f);
        host.wr_reg(8'h40, 8'h05);
        rchk(8'h40, 8'h0a);
        $display("unit timer test done");
        // Zero count keeps the unit asleep despite activity
        host.wr_reg(8'h38, 8'h00);
        wake(4'h8);
        waitn(2);
        chk("frozen unit", 8'h01, {7'h0, unit_sleep[3]});
        host.wr_reg(8'h38, 8'(cnt[3]));
        host.wr_reg(8'h3a, 8'hff);
        rchk(8'h3a, 8'h23);
        expect_sleep(1, cnt[1], SEC * MIN);
        host.wr_reg(8'h3a, 8'h00);
        $display("resolution test done");
        // Standby count starts once the last unit sleeps
        wake(4'h1);
        host.wr_reg(8'h39, 8'h02);
        waitn(4 * cnt[0] - 2);
        chk("chip early", 8'h00, {7'h0, chip_sleep});
        waitn(10);
        chk("chip late", 8'h01, {7'h0, chip_sleep});
        $display("standby test done");
        pb = {6'($urandom_range(63, 16)), 4'h0};
        gb = {7'($urandom_range(127, 32)), 3'h0};
        host.wr_reg(8'h33, pb[9:2]);
        host.wr_reg(8'h34, gb[9:2]);
        for (k = -1; k < 13; k++)
            probe(pb + 10'(k), 1'b1);
        for (k = -1; k < 9; k++)
            probe(gb + 10'(k), 1'b1);
        repeat (6) probe(10'($urandom), 1'b1);
        host.wr_reg(8'h32, 8'h00);
        probe(pb, 1'b0);
        probe(gb + 10'h004, 1'b0);
        host.wr_reg(8'h32, 8'h80);
        host.wr_reg(8'h33, 8'h00);
        pb = 10'h000;
        probe(10'h000, 1'b1);
        $display("decode test done");
        // Unit or chip enable cleared: units stay awake
        for (k = 0; k < 2; k++) begin
            host.wr_reg(8'h32, k == 0 ? 8'h0f : 8'h80);
            wake(4'hf);
            waitn(40);
            chk("disabled", 8'h00, {4'h0, unit_sleep});
        end
        $display("enable test done");
        k = $urandom_range(7, 0);
        v = 8'h01 << k;
        host.wr_reg(8'h27, 8'(k + 1));
        host.wr_reg(8'h28, 8'h00);
        host.wr_reg(8'h29, 8'h00);
        host.wr_reg(8'h18, 8'h00);
        irq = 4'h8;
        waitn(2);
        chk("pin out", v, pin_out);
        chk("pin oe", ~v, pin_oe_n);
        irq = 4'h0;
        waitn(2);
        chk("pin low", 8'h00, pin_out);
        // Serial B, serial A and floppy nibbles drive the same pin
        host.wr_reg(8'h27, 8'h00);
        for (u = 0; u < 3; u++) begin
            host.wr_reg(u == 2 ? 8'h29 : 8'h28,
                        u == 0 ? 8'(k + 1) : 8'(k + 1) << 4);
            irq = 4'h1 << u;
            waitn(2);
            chk("unit pin", v, pin_out);
            irq = 4'h0;
            host.wr_reg(u == 2 ? 8'h29 : 8'h28, 8'h00);
        end
        host.wr_reg(8'h27, 8'(k + 1));
        host.wr_reg(8'h18, v);
        waitn(2);
        chk("shared idle", 8'hff, pin_oe_n);
        irq = 4'h8;
        waitn(2);
        chk("shared on", ~v, pin_oe_n);
        host.wr_reg(8'h31, 8'h04);
        irq = 4'($urandom);
        waitn(2);
        chk("serial oe", 8'hff, pin_oe_n);
        chk("serirq", {4'h0, irq}, {4'h0, serirq});
        host.wr_reg(8'h31, 8'h00);
        waitn(2);
        chk("legacy serirq", 8'h00, {4'h0, serirq});
        $display("interrupt test done");
        tally_and_finish();
    end
endmodule
